// ---- rtl/tppc_consts.svh ----
// Constants of the three-phase PWM controller: register offsets, field positions, reset values.
// Assumes a byte-addressed AXI4-Lite slave with 8 address bits and one 32-bit word per register.
`ifndef TPPC_CONSTS_SVH
`define TPPC_CONSTS_SVH

// Register byte offsets
`define TPPC_OFS_HALF_PERIOD 8'h00
`define TPPC_OFS_DEAD_TIME 8'h04
`define TPPC_OFS_MIN_PULSE 8'h08
`define TPPC_OFS_SYNC_WIDTH 8'h0C
`define TPPC_OFS_DUTY_A 8'h10
`define TPPC_OFS_DUTY_B 8'h14
`define TPPC_OFS_DUTY_C 8'h18
`define TPPC_OFS_SEGMENT 8'h1C
`define TPPC_OFS_GATE_CHOP 8'h20
`define TPPC_OFS_MODE_CTRL 8'h24
`define TPPC_OFS_IO_SHUT_SEL 8'h28
`define TPPC_OFS_SW_TRIP 8'h2C
`define TPPC_OFS_STATUS 8'h30

// Field positions
`define TPPC_MODE_DOUBLE_BIT 6
`define TPPC_SEG_CROSS_LSB 6
`define TPPC_GATE_HIGH_EN_BIT 8
`define TPPC_GATE_LOW_EN_BIT 9
`define TPPC_STAT_TRIP_BIT 0
`define TPPC_STAT_SHUT_BIT 1
`define TPPC_STAT_POL_BIT 2
`define TPPC_STAT_HALF_BIT 3

// Reset values
`define TPPC_HALF_PERIOD_RST 16'h0100
`define TPPC_SYNC_WIDTH_RST 8'h27

// Bus answers
`define TPPC_RESP_OKAY 2'h0
`define TPPC_RESP_SLVERR 2'h2

`endif

// ---- rtl/tppc_pkg.sv ----
// Types of the three-phase PWM controller: timing unit states and the block's whole state record.
// Assumes the constants header is compiled alongside; the package itself holds no numbers of its own.
package tppc_pkg;

  // Timing unit states, one-hot
  typedef enum logic [2:0] {
    TPPC_HALT = 3'h1,
    TPPC_FIRST = 3'h2,
    TPPC_SECOND = 3'h4
  } tppc_state_t;

  // Every flip-flop of the controller
  typedef struct packed {
    logic awready, wready, arready, aw_hold, w_hold, bvalid, rvalid;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] tm_sw, pd_sw, tm_act, pd_act;
    logic [9:0] dt_sw, dt_act, gate_sw, gate_act;
    logic [7:0] sync_sw, sync_cnt, chop_cnt;
    logic [2:0][15:0] duty_sw, duty_act;
    logic [8:0] seg_sw, seg_act;
    logic dbl_sw, dbl_act, shut_lat, shut_prev, sync_o, chop;
    logic [11:0] io_sel, io_s1, io_s2;
    logic trip_s1, trip_s2, pol_s1, pol_s2;
    tppc_state_t st;
    logic [15:0] cnt;
    logic [5:0] drive;
    logic sync_irq, shut_irq;
  } tppc_regs_t;

endpackage : tppc_pkg

// ---- rtl/tppc_top.sv ----
// Three-phase centre-based PWM controller with AXI4-Lite registers, dead time, crossover and chopping.
// Assumes clk at the instruction rate; trip, polarity and I/O lines are asynchronous pins.
//
// Overview of operation
// - Six outputs form three complementary high/low pairs for phases A, B, C.
// - Polarity select pin decides active high or low; OFF level follows it.
// - Period, dead-time and minimum-pulse registers each set by software.
// - Duty registers A, B, C set the duty cycle of pairs A, B, C.
// - Segment register has one disable bit per output; a set bit keeps that output inactive.
// - Three crossover bits swap high and low timing signals of a pair.
// - Eight-bit gate field sets the high-frequency chopping frequency.
// - Separate chopping enables for the high-side and the low-side outputs.
// - Single update mode loads new values once per period, symmetric patterns.
// - Double update mode reloads again at the period midpoint.
// - Mode-control bit 6 selects single or double update.
// - Sync pulse at each period start, plus midpoint in double mode.
// - Trip input low forces all six outputs to their OFF level at once.
// - Each selected I/O line acts as a shutdown exactly like the trip input; here an I/O line shuts down when high, the trip input when low.
// - Hardware shutdown paths bypass all clocked logic.
// - Status reports trip level, polarity level and first or second half.
// - Shutdown sources merge into a reset holding the timing unit inactive.
// - Whole controller runs at the instruction clock; one cycle is the time unit.
// - One interrupt on each sync rising edge, another on any shutdown.
// - Timing unit counts with 16 bits; its raw outputs are active low.
// - Centre-based complementary pairs with dead time between turn-off and turn-on.
// - Period register holds half a period in clock cycles.
// - Dead time equals register value times two clock cycles; zero means none.
// - Sync pulse lasts register value plus one cycles; register resets to 0x27.
// - Sync rising edge transfers configuration, duty and segment values into use.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tppc_consts.svh"

module tppc_top
  import tppc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shutdown and polarity pins
  input wire logic trip_shutdown_input,
  input wire logic output_polarity_select,
  input wire logic [11:0] io_lines,
  // Gate drive outputs
  output logic phase_a_high_drive,
  output logic phase_a_low_drive,
  output logic phase_b_high_drive,
  output logic phase_b_low_drive,
  output logic phase_c_high_drive,
  output logic phase_c_low_drive,
  // Sync and event outputs
  output logic period_sync_pulse,
  output logic sync_irq,
  output logic shutdown_irq
);

  tppc_regs_t q, d;
  logic [31:0] wdata_m;
  logic do_write, start, last, hw_sync_shut, shut_any, sw_set, lat_clr, hw_off;
  logic [16:0] pos;
  logic [2:0] hi_on, lo_on;
  logic [5:0] on_vec;
  logic hs, ls;

  // Register readback, shared by the read channel and the byte-lane merge of writes
  function automatic logic [31:0] tppc_read(input tppc_regs_t r, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `TPPC_OFS_HALF_PERIOD: v[15:0] = r.tm_sw;
      `TPPC_OFS_DEAD_TIME: v[9:0] = r.dt_sw;
      `TPPC_OFS_MIN_PULSE: v[15:0] = r.pd_sw;
      `TPPC_OFS_SYNC_WIDTH: v[7:0] = r.sync_sw;
      `TPPC_OFS_DUTY_A: v[15:0] = r.duty_sw[0];
      `TPPC_OFS_DUTY_B: v[15:0] = r.duty_sw[1];
      `TPPC_OFS_DUTY_C: v[15:0] = r.duty_sw[2];
      `TPPC_OFS_SEGMENT: v[8:0] = r.seg_sw;
      `TPPC_OFS_GATE_CHOP: v[9:0] = r.gate_sw;
      `TPPC_OFS_MODE_CTRL: v[`TPPC_MODE_DOUBLE_BIT] = r.dbl_sw;
      `TPPC_OFS_IO_SHUT_SEL: v[11:0] = r.io_sel;
      `TPPC_OFS_STATUS:
      begin
        v[`TPPC_STAT_TRIP_BIT] = r.trip_s2;
        v[`TPPC_STAT_SHUT_BIT] = r.shut_lat;
        v[`TPPC_STAT_POL_BIT] = r.pol_s2;
        v[`TPPC_STAT_HALF_BIT] = (r.st == TPPC_SECOND);
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction : tppc_read

  // Unmapped offsets answer SLVERR; the software-trip word reads as zero
  function automatic logic tppc_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `TPPC_OFS_STATUS);
  endfunction : tppc_mapped

  // Byte-lane merge of a write into the old register word
  function automatic logic [31:0] tppc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[8*i +: 8] = new_v[8*i +: 8];
    end
    return m;
  endfunction : tppc_merge

  // Next-state logic for the whole controller
  always_comb
  begin
    d = q;
    sw_set = 1'b0;
    lat_clr = 1'b0;
    start = 1'b0;
    // Two-stage synchronisers for the asynchronous pins
    d.trip_s1 = trip_shutdown_input;
    d.trip_s2 = q.trip_s1;
    d.pol_s1 = output_polarity_select;
    d.pol_s2 = q.pol_s1;
    d.io_s1 = io_lines;
    d.io_s2 = q.io_s1;
    d.sync_irq = 1'b0;
    // Write address and data are taken in either order and held until both are here
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_hold = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    do_write = q.aw_hold && q.w_hold && !q.bvalid;
    wdata_m = tppc_merge(tppc_read(q, q.aw_addr), q.w_data, q.w_strb);
    if (do_write)
    begin
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = tppc_mapped(q.aw_addr) ? `TPPC_RESP_OKAY : `TPPC_RESP_SLVERR;
      case (q.aw_addr)
        `TPPC_OFS_HALF_PERIOD: d.tm_sw = wdata_m[15:0];
        `TPPC_OFS_DEAD_TIME: d.dt_sw = wdata_m[9:0];
        `TPPC_OFS_MIN_PULSE: d.pd_sw = wdata_m[15:0];
        `TPPC_OFS_SYNC_WIDTH: d.sync_sw = wdata_m[7:0];
        `TPPC_OFS_DUTY_A: d.duty_sw[0] = wdata_m[15:0];
        `TPPC_OFS_DUTY_B: d.duty_sw[1] = wdata_m[15:0];
        `TPPC_OFS_DUTY_C: d.duty_sw[2] = wdata_m[15:0];
        `TPPC_OFS_SEGMENT: d.seg_sw = wdata_m[8:0];
        `TPPC_OFS_GATE_CHOP: d.gate_sw = wdata_m[9:0];
        `TPPC_OFS_MODE_CTRL: d.dbl_sw = wdata_m[`TPPC_MODE_DOUBLE_BIT];
        `TPPC_OFS_IO_SHUT_SEL: d.io_sel = wdata_m[11:0];
        `TPPC_OFS_SW_TRIP: sw_set = 1'b1;
        `TPPC_OFS_STATUS: lat_clr = wdata_m[`TPPC_STAT_SHUT_BIT];
        default: ;
      endcase
    end
    else if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    // No new write is taken while a response waits
    d.awready = !d.aw_hold && !d.bvalid;
    d.wready = !d.w_hold && !d.bvalid;
    // Read: one outstanding, answered on the next edge
    if (s_axi_arvalid && q.arready)
    begin
      d.rdata = tppc_read(q, s_axi_araddr);
      d.rresp = tppc_mapped(s_axi_araddr) ? `TPPC_RESP_OKAY : `TPPC_RESP_SLVERR;
      d.rvalid = 1'b1;
      d.arready = 1'b0;
    end
    else if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    // Shutdown merge; a new request beats a clear in the same cycle
    hw_sync_shut = !q.trip_s2 || (|(q.io_s2 & q.io_sel));
    if (hw_sync_shut || sw_set)
      d.shut_lat = 1'b1;
    else if (lat_clr)
      d.shut_lat = 1'b0;
    shut_any = hw_sync_shut || q.shut_lat;
    d.shut_prev = shut_any;
    d.shut_irq = shut_any && !q.shut_prev;
    // Half-period counter, 16 bits, one step per instruction cycle
    last = ({1'b0, q.cnt} + 17'h1) >= {1'b0, q.tm_act};
    case (q.st)
      TPPC_HALT: start = 1'b1;
      TPPC_FIRST:
      begin
        if (last)
        begin
          d.st = TPPC_SECOND;
          d.cnt = 16'h0;
          start = q.dbl_act;
        end
        else
          d.cnt = q.cnt + 16'h1;
      end
      TPPC_SECOND:
      begin
        if (last)
          start = 1'b1;
        else
          d.cnt = q.cnt + 16'h1;
      end
      default: d.st = TPPC_HALT;
    endcase
    if (shut_any)
      start = 1'b0;
    // Sync rising edge: new values enter the timing and output units together
    if (start)
    begin
      d.st = (q.st == TPPC_FIRST) ? TPPC_SECOND : TPPC_FIRST;
      d.cnt = 16'h0;
      d.tm_act = q.tm_sw;
      d.dt_act = q.dt_sw;
      d.pd_act = q.pd_sw;
      d.duty_act = q.duty_sw;
      d.seg_act = q.seg_sw;
      d.gate_act = q.gate_sw;
      d.dbl_act = q.dbl_sw;
      d.sync_o = 1'b1;
      d.sync_cnt = q.sync_sw;
      d.sync_irq = 1'b1;
    end
    else if (q.sync_o)
    begin
      if (q.sync_cnt == 8'h0)
        d.sync_o = 1'b0;
      else
        d.sync_cnt = q.sync_cnt - 8'h1;
    end
    // Held in reset while any shutdown stands
    if (shut_any)
    begin
      d.st = TPPC_HALT;
      d.cnt = 16'h0;
      d.sync_o = 1'b0;
    end
    // Chopping square wave: half period of gate field plus one cycles
    if (q.chop_cnt >= q.gate_act[7:0])
    begin
      d.chop_cnt = 8'h0;
      d.chop = !q.chop;
    end
    else
      d.chop_cnt = q.chop_cnt + 8'h1;
    // Centre-based compare: distance from the nearer period edge
    pos = (q.st == TPPC_SECOND) ? ({1'b0, q.tm_act} - {1'b0, q.cnt} - 17'h1) : {1'b0, q.cnt};
    for (int k = 0; k < 3; k++)
    begin
      // Dead time of dt cycles on each side of the centre edge gives 2*dt between pairs
      hi_on[k] = (q.st != TPPC_HALT) && ((18'(pos) + 18'(q.duty_act[k])) >= (18'(q.tm_act) + 18'(q.dt_act)))
                 && ((18'(q.duty_act[k])) >= (18'(q.dt_act) + 18'(q.pd_act)));
      lo_on[k] = (q.st != TPPC_HALT)
                 && ((18'(pos) + 18'(q.duty_act[k]) + 18'(q.dt_act)) < 18'(q.tm_act))
                 && ((18'(q.duty_act[k]) + 18'(q.dt_act) + 18'(q.pd_act)) <= 18'(q.tm_act));
      // Output unit: crossover, per-output disable, then chopping on each side
      hs = q.seg_act[`TPPC_SEG_CROSS_LSB + k] ? lo_on[k] : hi_on[k];
      ls = q.seg_act[`TPPC_SEG_CROSS_LSB + k] ? hi_on[k] : lo_on[k];
      on_vec[2*k] = hs && !q.seg_act[2*k]
                    && (q.chop || !q.gate_act[`TPPC_GATE_HIGH_EN_BIT]);
      on_vec[2*k+1] = ls && !q.seg_act[2*k+1]
                      && (q.chop || !q.gate_act[`TPPC_GATE_LOW_EN_BIT]);
    end
    // Raw commands are active low; the pin sets the sense at the output, so a polarity
    // change never waits on a synchroniser and a reset parks every switch off
    d.drive = ~on_vec;
    if (shut_any)
      d.drive = 6'h3F;
  end

  // State register; asynchronous reset to constants only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.trip_s1 <= 1'b1;
      q.trip_s2 <= 1'b1;
      q.shut_prev <= 1'b1;
      q.st <= TPPC_HALT;
      q.drive <= 6'h3F;
      q.tm_sw <= `TPPC_HALF_PERIOD_RST;
      q.sync_sw <= `TPPC_SYNC_WIDTH_RST;
    end
    else
      q <= d;
  end

  // Unclocked shutdown path: pins reach the outputs even with the clock stopped
  assign hw_off = reset || !trip_shutdown_input || (|(io_lines & q.io_sel));
  assign phase_a_high_drive = (hw_off || q.drive[0]) ? !output_polarity_select : output_polarity_select;
  assign phase_a_low_drive = (hw_off || q.drive[1]) ? !output_polarity_select : output_polarity_select;
  assign phase_b_high_drive = (hw_off || q.drive[2]) ? !output_polarity_select : output_polarity_select;
  assign phase_b_low_drive = (hw_off || q.drive[3]) ? !output_polarity_select : output_polarity_select;
  assign phase_c_high_drive = (hw_off || q.drive[4]) ? !output_polarity_select : output_polarity_select;
  assign phase_c_low_drive = (hw_off || q.drive[5]) ? !output_polarity_select : output_polarity_select;

  // Registered bus and event outputs
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign period_sync_pulse = q.sync_o;
  assign sync_irq = q.sync_irq;
  assign shutdown_irq = q.shut_irq;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_sync_start;
    $rose(q.sync_o);
  endsequence
  sequence s_mid_edge;
    (q.st == TPPC_FIRST) && last && !shut_any;
  endsequence

  property p_sync_irq;
    s_sync_start |-> q.sync_irq;
  endproperty
  a_sync_irq: assert property (p_sync_irq) else $error("sync edge without interrupt");

  property p_load;
    s_sync_start |-> (q.duty_act == $past(q.duty_sw)) && (q.seg_act == $past(q.seg_sw));
  endproperty
  a_load: assert property (p_load) else $error("values not latched at sync edge");

  property p_shut_halt;
    q.shut_lat |=> (q.st == TPPC_HALT) && !q.sync_o;
  endproperty
  a_shut_halt: assert property (p_shut_halt) else $error("timing unit runs during shutdown");

  property p_trip_off;
    !trip_shutdown_input |-> {phase_a_high_drive, phase_a_low_drive, phase_b_high_drive, phase_b_low_drive,
                              phase_c_high_drive, phase_c_low_drive} == {6{!output_polarity_select}};
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("outputs not off under trip");

  property p_io_off;
    (|(io_lines & q.io_sel)) |-> {phase_a_high_drive, phase_a_low_drive, phase_b_high_drive, phase_b_low_drive,
                                  phase_c_high_drive, phase_c_low_drive} == {6{!output_polarity_select}};
  endproperty
  a_io_off: assert property (p_io_off) else $error("outputs not off under I/O shutdown");

  property p_dead;
    !((on_vec[0] && on_vec[1]) || (on_vec[2] && on_vec[3]) || (on_vec[4] && on_vec[5]));
  endproperty
  a_dead: assert property (p_dead) else $error("both switches of a pair commanded on");

  property p_mid_double;
    s_mid_edge ##0 q.dbl_act |=> q.sync_irq && q.sync_o && (q.st == TPPC_SECOND) && (q.cnt == 16'h0);
  endproperty
  a_mid_double: assert property (p_mid_double) else $error("no midpoint sync in double mode");

  property p_mid_single;
    s_mid_edge ##0 !q.dbl_act |=> !q.sync_irq && (q.st == TPPC_SECOND);
  endproperty
  a_mid_single: assert property (p_mid_single) else $error("midpoint reload in single mode");

  property p_seg_off;
    q.seg_act[0] && !shut_any |=> q.drive[0];
  endproperty
  a_seg_off: assert property (p_seg_off) else $error("disabled output driven on");

  property p_half_bound;
    (q.st != TPPC_HALT) && (q.tm_act != 16'h0) |-> q.cnt < q.tm_act;
  endproperty
  a_half_bound: assert property (p_half_bound) else $error("counter beyond half period");

endmodule : tppc_top

`default_nettype wire

// ---- verification/tppc_gate_model.sv ----
// Gate-driver model of the six drive pins: on-cycles per switch over each period.
// Assumes a one-cycle period marker and the polarity level the controller sees.
`timescale 1ns/1ns
`default_nettype none

module tppc_gate_model (
  // Clock and period marker
  input wire logic clk,
  input wire logic sync_evt,
  // Drive pins and the level that means on
  input wire logic pol,
  input wire logic [5:0] drv,
  // Counts of the last whole period, shoot-through cycles
  output logic [5:0][15:0] snap,
  output logic [15:0] shoot = 16'h0
);
  logic [5:0][15:0] cnt_q;
  logic [5:0] on;

  // A switch conducts when its pin sits at the selected level
  assign on = pol ? drv : ~drv;

  // Counts restart at each marker, so a snapshot spans one period
  always @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      snap[i] <= sync_evt ? cnt_q[i] : snap[i];
      cnt_q[i] <= sync_evt ? 16'(on[i]) : cnt_q[i] + 16'(on[i]);
    end
    // Both switches of one leg on shorts the supply
    if ((on[5] & on[4]) | (on[3] & on[2]) | (on[1] & on[0]))
      shoot <= shoot + 16'h1;
  end
endmodule : tppc_gate_model

`default_nettype wire

// ---- verification/three_phase_pwm_controller_test.sv ----
// Testbench of the three-phase PWM controller: bus, timing, shutdown, update modes.
// Assumes the design sources and the gate model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "tppc_consts.svh"

module three_phase_pwm_controller_test;
  logic clk = 1'h0, reset = 1'h1, trip = 1'h1, pol = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, sync_p, sync_irq, shut_irq;
  logic [1:0] bresp, rresp;
  logic [11:0] io = 12'h0;
  logic [5:0] drv;
  logic [5:0][15:0] snap;
  logic [15:0] shoot;
  int n_errors = 0, n_checks = 0, n_sync = 0, n_sirq = 0;

  tppc_top dut_u (.clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trip_shutdown_input(trip), .output_polarity_select(pol), .io_lines(io),
    .phase_a_high_drive(drv[5]), .phase_a_low_drive(drv[4]),
    .phase_b_high_drive(drv[3]), .phase_b_low_drive(drv[2]),
    .phase_c_high_drive(drv[1]), .phase_c_low_drive(drv[0]),
    .period_sync_pulse(sync_p), .sync_irq(sync_irq), .shutdown_irq(shut_irq));

  tppc_gate_model gm_u (.clk(clk), .sync_evt(sync_irq), .pol(pol), .drv(drv),
    .snap(snap), .shoot(shoot));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Interrupt pulses counted at the edge that ends them
  always @(posedge clk)
  begin
    if (sync_irq === 1'h1) n_sync++;
    if (shut_irq === 1'h1) n_sirq++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      ta |= awvalid & awready;
      tw |= wvalid & wready;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!(ta && tw) && n < 100);
    do
    begin
      @(posedge clk);
      n++;
    end while (bvalid !== 1'h1 && n < 200);
    bready <= 1'h0;
    chk(n < 200, 32'h1);
    chk(bresp, er);
  endtask : axw

  // Read one word and compare the masked data and the response
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, e,
                     output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    // Address stands until the slave is seen ready at an edge
    do
    begin
      @(posedge clk);
      n++;
    end while (arready !== 1'h1 && n < 200);
    arvalid <= 1'h0;
    do
    begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'h1 && n < 200);
    d = rdata;
    rready <= 1'h0;
    chk(n < 200, 32'h1);
    chk(rresp, er);
    chk(d & m, e);
  endtask : axr

  // Returns cycles waited in this call for the sync interrupt; a hang counts as a mismatch
  task automatic wait_sync(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (sync_irq !== 1'h1 && n < 3000);
    chk(n < 3000, 32'h1);
  endtask : wait_sync

  task automatic sync_width(output int w);
    int n;
    wait_sync(n);
    w = 0;
    while (sync_p === 1'h1 && w < 300)
    begin
      w++;
      @(negedge clk);
    end
  endtask : sync_width

  // New settings land at a sync, so the third sync closes a clean period
  task automatic run_cfg(input logic [31:0] seg, gate, pd, input logic [5:0][15:0] exp);
    int n;
    axw(`TPPC_OFS_SEGMENT, seg, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_GATE_CHOP, gate, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_MIN_PULSE, pd, `TPPC_RESP_OKAY);
    repeat (3) wait_sync(n);
    @(negedge clk);
    chk(n, 32'h80);
    for (int i = 0; i < 6; i++)
      chk(snap[i], exp[i]);
  endtask : run_cfg

  task automatic t_reset;
    int n, w;
    logic [31:0] d;
    axr(`TPPC_OFS_HALF_PERIOD, `TPPC_RESP_OKAY, 32'hFFFFFFFF, 32'h100, d);
    axr(`TPPC_OFS_SYNC_WIDTH, `TPPC_RESP_OKAY, 32'hFFFFFFFF, 32'h27, d);
    axr(`TPPC_OFS_MODE_CTRL, `TPPC_RESP_OKAY, 32'hFFFFFFFF, 32'h0, d);
    axr(8'h3C, `TPPC_RESP_SLVERR, 32'hFFFFFFFF, 32'h0, d);
    axw(8'h3C, 32'hFFFFFFFF, `TPPC_RESP_SLVERR);
    sync_width(w);
    chk(w, 32'h28);
    wait_sync(n);
    wait_sync(n);
    chk(n, 32'h200);
  endtask : t_reset

  task automatic t_timing;
    int w;
    axw(`TPPC_OFS_HALF_PERIOD, 32'h40, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_DEAD_TIME, 32'h4, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_SYNC_WIDTH, 32'h3, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_DUTY_A, 32'h28, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_DUTY_B, 32'h10, `TPPC_RESP_OKAY);
    axw(`TPPC_OFS_DUTY_C, 32'h30, `TPPC_RESP_OKAY);
    run_cfg(32'h0, 32'h0, 32'h0, {16'h48, 16'h28, 16'h18, 16'h58, 16'h58, 16'h18});
    sync_width(w);
    chk(w, 32'h4);
    run_cfg(32'h49, 32'h0, 32'hD, {16'h0, 16'h48, 16'h0, 16'h0, 16'h58, 16'h0});
    run_cfg(32'h0, 32'h100, 32'h0, {16'h24, 16'h28, 16'hC, 16'h58, 16'h2C, 16'h18});
    run_cfg(32'h0, 32'h200, 32'h0, {16'h48, 16'h14, 16'h18, 16'h2C, 16'h58, 16'hC});
  endtask : t_timing

  // Outputs parked, one shutdown interrupt, latch reported
  task automatic off_chk(input int s0);
    logic [31:0] d;
    repeat (6) @(negedge clk);
    chk(drv, {6{~pol}});
    chk(n_sirq - s0, 32'h1);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h2, 32'h2, d);
  endtask : off_chk

  task automatic recover;
    int n;
    logic [31:0] d;
    axw(`TPPC_OFS_STATUS, 32'h2, `TPPC_RESP_OKAY);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h2, 32'h0, d);
    wait_sync(n);
  endtask : recover

  task automatic t_io;
    int s0;
    logic [31:0] d;
    axw(`TPPC_OFS_IO_SHUT_SEL, 32'h8, `TPPC_RESP_OKAY);
    @(posedge clk);
    io <= 12'h004;
    repeat (6) @(negedge clk);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h2, 32'h0, d);
    s0 = n_sirq;
    @(posedge clk);
    io <= 12'h00C;
    #1 chk(drv, {6{~pol}});
    off_chk(s0);
    @(posedge clk);
    io <= 12'h000;
    recover;
  endtask : t_io

  task automatic t_sw;
    int s0;
    s0 = n_sirq;
    axw(`TPPC_OFS_SW_TRIP, 32'h1, `TPPC_RESP_OKAY);
    off_chk(s0);
    recover;
  endtask : t_sw

  // Trip pin, then a polarity flip while parked
  task automatic t_trip;
    int s0;
    logic [31:0] d;
    s0 = n_sirq;
    @(posedge clk);
    trip <= 1'h0;
    #1 chk(drv, {6{~pol}});
    @(posedge clk);
    pol <= 1'h0;
    #1 chk(drv, 32'h3F);
    off_chk(s0);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h5, 32'h0, d);
    @(posedge clk);
    trip <= 1'h1;
    repeat (6) @(negedge clk);
    chk(drv, 32'h3F);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h5, 32'h1, d);
    recover;
  endtask : t_trip

  task automatic t_double;
    int n, s;
    logic [31:0] d, d2;
    axw(`TPPC_OFS_MODE_CTRL, 32'h40, `TPPC_RESP_OKAY);
    repeat (3) wait_sync(n);
    chk(n, 32'h40);
    s = n_sync;
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h0, 32'h0, d);
    wait_sync(n);
    chk(n_sync - s, 32'h1);
    axr(`TPPC_OFS_STATUS, `TPPC_RESP_OKAY, 32'h0, 32'h0, d2);
    chk(d2[3], {31'h0, !d[3]});
  endtask : t_double

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    t_reset;
    t_timing;
    t_io;
    t_sw;
    t_trip;
    run_cfg(32'h0, 32'h0, 32'h0, {16'h48, 16'h28, 16'h18, 16'h58, 16'h58, 16'h18});
    t_double;
    chk(shoot, 32'h0);
    give_verdict;
  end

  // Watchdog, far beyond the roughly 5k cycles the run needs
  initial
  begin
    #1000000;
    n_errors++;
    give_verdict;
  end
endmodule : three_phase_pwm_controller_test

`default_nettype wire
